// ### hw/bfp_delay.sv
// One detection or release delay counter.
// Assumes tick comes from the shared time base or is held high.
`timescale 1ns/1ps
module bfp_delay
  import bfp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cen,
  bfp_dly_if.dly d
);

  bfp_dly_st_t s_r;
  bfp_dly_st_t s_nxt;

  // Dropping run clears the count, so an interrupted delay restarts
  always_comb begin
    s_nxt = s_r;
    d.done = 1'b0;
    if (!d.run) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= d.limit) begin
      d.done = 1'b1;
      s_nxt.cnt = '0;
    end else if (d.tick) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else if (cen) begin
      s_r <= s_nxt;
    end
  end

  a_cnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(cen) && !$past(d.run)) |-> (s_r.cnt == '0))
    else $error("delay count not cleared after run dropped");

endmodule

// ### hw/bfp_dly_if.sv
// Link between the arbiter and one delay counter unit.
// Assumes the arbiter drives run, tick and limit each cycle.
`timescale 1ns/1ps
interface bfp_dly_if #(parameter int W = 16);
  logic run;
  logic tick;
  logic [W-1:0] limit;
  logic done;
  modport ctl (output run, output tick, output limit, input done);
  modport dly (input run, input tick, input limit, output done);
endinterface

// ### hw/bfp_pkg.sv
// Constants, register map and state types of the battery fault
// priority logic.
// Assumes a 200 MHz pclk and comparator levels synchronous to it.
package bfp_pkg;

  localparam int CLK_PERIOD_NS = 5;
  // Base tick of the shared delay counter; delays count these ticks
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC_I = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_SHIFT = 4;
  localparam int TICK_SHORT_I = ((TICK_CYC_I >> SHORT_SHIFT) > 0) ?
                                (TICK_CYC_I >> SHORT_SHIFT) : 1;
  localparam int PRE_W = 16;
  localparam logic [PRE_W-1:0] TICK_CYC = PRE_W'(TICK_CYC_I);
  localparam logic [PRE_W-1:0] TICK_SHORT_CYC = PRE_W'(TICK_SHORT_I);

  // Short-circuit delay counts raw clock cycles, never shortened
  localparam int SC_DLY_NS = 10000;
  localparam int SC_DLY_I = (SC_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W = 16;
  localparam logic [DLY_W-1:0] SC_DLY_CYC = DLY_W'(SC_DLY_I);

  // Delay units
  localparam int U_OC = 0;
  localparam int U_OD = 1;
  localparam int U_OCUR = 2;
  localparam int U_SC = 3;
  localparam int U_XCHG = 4;
  localparam int NUNIT = 5;

  // Register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DLY_BASE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_DLY_LAST = 8'h20;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 4;
  localparam int DLY_OC_DET = 0;
  localparam int DLY_OC_REL = 1;
  localparam int DLY_OD_DET = 2;
  localparam int DLY_OD_REL = 3;
  localparam int DLY_OCUR_DET = 4;
  localparam int DLY_OCUR_REL = 5;
  localparam int DLY_XCHG_DET = 6;
  localparam int DLY_XCHG_REL = 7;
  localparam int NDLY = 8;
  // Reset delays in ticks, index 7 first
  localparam logic [NDLY-1:0][DLY_W-1:0] DLY_RST = {
    16'h0010, 16'h0010, 16'h0010, 16'h000A,
    16'h0010, 16'h0064, 16'h0010, 16'h03E8};

  // Status bit positions
  localparam int ST_OC = 0;
  localparam int ST_OD = 1;
  localparam int ST_OCUR = 2;
  localparam int ST_SC = 3;
  localparam int ST_XCHG = 4;
  localparam int ST_STANDBY = 5;
  localparam int ST_PULL_UP = 6;
  localparam int ST_PULL_DN = 7;
  localparam int ST_CHG = 8;
  localparam int ST_DIS = 9;
  localparam int ST_SHORT = 10;
  localparam int ST_W = 11;

  typedef struct packed {
    logic [DLY_W-1:0] cnt;
  } bfp_dly_st_t;

  typedef struct packed {
    logic [PRE_W-1:0] presc;
    logic oc;
    logic od;
    logic ocur;
    logic sc;
    logic xchg;
    logic od_after_oc;
    logic standby;
    logic chg_gate;
    logic dis_gate;
    logic pull_up;
    logic pull_dn;
    logic [NDLY-1:0][DLY_W-1:0] dly;
    logic [31:0] prdata;
    logic loaded;
  } bfp_top_st_t;

  localparam bfp_top_st_t TOP_RST = '{dly: DLY_RST, chg_gate: 1'b1,
                                      dis_gate: 1'b1, default: '0};

endpackage

// ### hw/bfp_top.sv
// Detection arbitration of a two-cell battery protector with APB access.
// Assumes comparator levels synchronous to pclk; T pin open reads low.
//
// Summary of operation
// - Charge gate low after over-charge delay
// - Discharge gate low, stand-by after over-discharge
// - Select high shortens every delay except short-circuit detection
// - Select low gives normal counter delays
// - Short-circuit detection delay ignores the select
// - Over-charge detection beats over-discharge detection
// - Over-discharge suspended, then restarted after over-charge
// - Over-discharge after over-charge: pull-up, no stand-by
// - Over-charge first leaves sense pin released
// - Over-charge first aborts over-current detection
// - Over-current first pulls sense pin down
// - Over-discharge first aborts over-current detection
// - Over-discharge: pull-up, drop pull-down, stand-by
// - Short-circuit detection runs fully independently
// - Excessive charger blocked by discharge-side detections
// - Excessive charger delay starts after gate high
`timescale 1ns/1ps
module bfp_top
  import bfp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cen,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic oc_cmp,
  input wire logic od_cmp,
  input wire logic ocur_cmp,
  input wire logic sc_cmp,
  input wire logic xchg_cmp,
  input wire logic oc_rel,
  input wire logic od_rel,
  input wire logic ocur_rel,
  input wire logic test_sel,
  output logic chg_gate,
  output logic dis_gate,
  output logic vm_pull_up,
  output logic vm_pull_dn,
  output logic standby
);

  bfp_top_st_t st_r;
  bfp_top_st_t st_nxt;

  logic shorten;
  logic [PRE_W-1:0] term;
  logic tick;
  logic oc_det_run;
  logic od_det_run;
  logic ocur_det_run;
  logic sc_det_run;
  logic xchg_det_run;
  logic [NUNIT-1:0] run_v;
  logic [NUNIT-1:0] tick_v;
  logic [NUNIT-1:0][DLY_W-1:0] limit_v;
  logic [NUNIT-1:0] done_v;
  logic hit_status;
  logic hit_dly;
  logic [ADDR_W-1:0] dly_off;
  logic [IDX_MSB-IDX_LSB:0] dly_idx;
  logic [ST_W-1:0] status_v;
  logic [31:0] rd_data;

  bfp_dly_if #(.W(DLY_W)) dif [NUNIT] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUNIT; gi++) begin : g_unit
      assign dif[gi].run = run_v[gi];
      assign dif[gi].tick = tick_v[gi];
      assign dif[gi].limit = limit_v[gi];
      assign done_v[gi] = dif[gi].done;
      bfp_delay u_dly (
        .pclk(pclk),
        .presetn(presetn),
        .cen(cen),
        .d(dif[gi])
      );
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;

    // Shared time base; test select only moves its terminal count
    shorten = test_sel;
    term = shorten ? TICK_SHORT_CYC : TICK_CYC;
    tick = (st_r.presc >= term - 1'b1);
    st_nxt.presc = tick ? '0 : st_r.presc + 1'b1;

    // Running detections from own flag; over-discharge, over-current and charger also gated by others
    oc_det_run = !st_r.oc && oc_cmp;
    od_det_run = !st_r.od && od_cmp && !oc_det_run;
    ocur_det_run = !st_r.ocur && ocur_cmp && !st_r.oc && !st_r.od;
    sc_det_run = !st_r.sc && sc_cmp;
    // Gate high already excludes the discharge-side states
    xchg_det_run = !st_r.xchg && xchg_cmp && st_r.dis_gate &&
                   !od_det_run && !ocur_det_run && !sc_det_run;

    run_v[U_OC] = st_r.oc ? oc_rel : oc_det_run;
    limit_v[U_OC] = st_r.oc ? st_r.dly[DLY_OC_REL] : st_r.dly[DLY_OC_DET];
    tick_v[U_OC] = tick;

    run_v[U_OD] = st_r.od ? od_rel : od_det_run;
    limit_v[U_OD] = st_r.od ? st_r.dly[DLY_OD_REL] : st_r.dly[DLY_OD_DET];
    tick_v[U_OD] = tick;

    run_v[U_OCUR] = st_r.ocur ? ocur_rel : ocur_det_run;
    limit_v[U_OCUR] = st_r.ocur ? st_r.dly[DLY_OCUR_REL] :
                      st_r.dly[DLY_OCUR_DET];
    tick_v[U_OCUR] = tick;

    // Detection counts raw cycles to a fixed limit; release uses the counter
    run_v[U_SC] = st_r.sc ? ocur_rel : sc_det_run;
    limit_v[U_SC] = st_r.sc ? st_r.dly[DLY_OCUR_REL] : SC_DLY_CYC;
    tick_v[U_SC] = st_r.sc ? tick : 1'b1;

    run_v[U_XCHG] = st_r.xchg ? !xchg_cmp : xchg_det_run;
    limit_v[U_XCHG] = st_r.xchg ? st_r.dly[DLY_XCHG_REL] :
                      st_r.dly[DLY_XCHG_DET];
    tick_v[U_XCHG] = tick;

    if (done_v[U_OC]) begin
      st_nxt.oc = !st_r.oc;
    end
    if (done_v[U_OCUR]) begin
      st_nxt.ocur = !st_r.ocur;
    end
    if (done_v[U_SC]) begin
      st_nxt.sc = !st_r.sc;
    end
    if (done_v[U_XCHG]) begin
      st_nxt.xchg = !st_r.xchg;
    end
    // Charger at the pin wakes the part before the gate is released
    if (st_r.standby && od_rel) begin
      st_nxt.standby = 1'b0;
    end
    if (done_v[U_OD]) begin
      st_nxt.od = !st_r.od;
      if (!st_r.od) begin
        st_nxt.od_after_oc = st_r.oc;
        st_nxt.standby = !st_r.oc;
        st_nxt.ocur = 1'b0;
      end else begin
        st_nxt.od_after_oc = 1'b0;
        st_nxt.standby = 1'b0;
      end
    end

    st_nxt.chg_gate = !(st_nxt.oc || st_nxt.xchg);
    st_nxt.dis_gate = !(st_nxt.od || st_nxt.ocur || st_nxt.sc);
    st_nxt.pull_up = st_nxt.od;
    // Over-charge alone never pulls the pin either way
    st_nxt.pull_dn = (st_nxt.ocur || st_nxt.sc) && !st_nxt.od;

    // APB decode
    hit_status = (paddr == REG_STATUS);
    hit_dly = (paddr >= REG_DLY_BASE) && (paddr <= REG_DLY_LAST) &&
              (paddr[IDX_LSB-1:0] == '0);
    dly_off = paddr - REG_DLY_BASE;
    dly_idx = dly_off[IDX_MSB:IDX_LSB];

    status_v = '0;
    status_v[ST_OC] = st_r.oc;
    status_v[ST_OD] = st_r.od;
    status_v[ST_OCUR] = st_r.ocur;
    status_v[ST_SC] = st_r.sc;
    status_v[ST_XCHG] = st_r.xchg;
    status_v[ST_STANDBY] = st_r.standby;
    status_v[ST_PULL_UP] = st_r.pull_up;
    status_v[ST_PULL_DN] = st_r.pull_dn;
    status_v[ST_CHG] = st_r.chg_gate;
    status_v[ST_DIS] = st_r.dis_gate;
    status_v[ST_SHORT] = shorten;

    rd_data = '0;
    if (hit_status) begin
      rd_data = 32'(status_v);
    end else if (hit_dly) begin
      rd_data = 32'(st_r.dly[dly_idx]);
    end

    // Read data is captured one cycle ahead so prdata comes from a flop
    pready = psel && penable && st_r.loaded && cen;
    pslverr = pready && !(hit_status || hit_dly);
    if (psel && !st_r.loaded) begin
      st_nxt.prdata = rd_data;
      st_nxt.loaded = 1'b1;
    end
    if (pready) begin
      st_nxt.loaded = 1'b0;
      if (pwrite && hit_dly) begin
        st_nxt.dly[dly_idx] = pwdata[DLY_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= TOP_RST;
    end else if (cen) begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign chg_gate = st_r.chg_gate;
  assign dis_gate = st_r.dis_gate;
  assign vm_pull_up = st_r.pull_up;
  assign vm_pull_dn = st_r.pull_dn;
  assign standby = st_r.standby;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_oc_gate_low: assert property ($rose(st_r.oc) |-> !chg_gate)
    else $error("charge gate high in over-charge state");

  a_od_standby: assert property (
    ($rose(st_r.od) && !$past(st_r.oc)) |-> (standby && !dis_gate))
    else $error("over-discharge entered without stand-by");

  a_short_tick: assert property (
    (cen && $past(cen) && shorten && $past(shorten))
    |-> (st_r.presc < TICK_SHORT_CYC))
    else $error("shortened time base overran its terminal");

  a_norm_tick: assert property (
    (cen && $past(tick) && !shorten && $past(!shorten))
    |-> ##1 (!tick [*8]))
    else $error("normal time base ticked too soon");

  a_sc_fixed: assert property (
    (!st_r.sc) |-> (limit_v[U_SC] == SC_DLY_CYC && tick_v[U_SC]))
    else $error("short-circuit delay depends on time base");

  a_od_yield: assert property (oc_det_run |-> !od_det_run)
    else $error("over-discharge ran during over-charge detection");

  a_od_resume: assert property (
    (st_r.oc && !st_r.od && od_cmp) |-> run_v[U_OD])
    else $error("over-discharge not resumed after over-charge");

  a_no_standby: assert property (
    (st_r.od && st_r.od_after_oc) |-> (!standby && vm_pull_up))
    else $error("stand-by entered after over-charge");

  a_oc_release: assert property (
    (st_r.oc && !st_r.ocur && !st_r.sc && !st_r.od)
    |-> (!vm_pull_up && !vm_pull_dn))
    else $error("sense pin pulled in over-charge state");

  a_ocur_abort: assert property (
    (st_r.oc || st_r.od) |-> !ocur_det_run)
    else $error("over-current detection not aborted");

  a_ocur_pull: assert property (
    (st_r.ocur && !st_r.od) |-> vm_pull_dn)
    else $error("no pull-down in over-current state");

  a_od_pull: assert property (st_r.od |-> (vm_pull_up && !vm_pull_dn))
    else $error("sense pin pull wrong in over-discharge");

  a_sc_indep: assert property (
    (!st_r.sc && sc_cmp) |-> run_v[U_SC])
    else $error("short-circuit detection held off");

  a_xchg_gate: assert property (
    xchg_det_run |-> (dis_gate && !od_det_run && !ocur_det_run))
    else $error("excessive charger detection while discharge blocked");

endmodule

// ### tb/bfp_pack_model.sv
// Behavioural pack: cells, charger and load seen through comparators.
// Assumes the bench changes its condition levels just after pclk edges.
`timescale 1ns/1ps
module bfp_pack_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] cond,
  input wire logic charger,
  input wire logic load_off,
  input wire logic test_mode,
  output logic [4:0] cmp,
  output logic oc_rel,
  output logic od_rel,
  output logic ocur_rel,
  output logic test_sel
);
  // Comparators settle one edge after the cell change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp <= 5'h00;
      oc_rel <= 1'b0;
      od_rel <= 1'b0;
      ocur_rel <= 1'b0;
    end else begin
      cmp <= cond;
      oc_rel <= !cond[0];
      od_rel <= charger;
      ocur_rel <= load_off;
    end
  end
  // Select held low except for shortened test runs
  assign test_sel = test_mode;
endmodule

// ### tb/tb_bfp_top.sv
// Self-checking bench for the fault priority logic over APB.
// Assumes the pack model drives comparators; cen is held high.
`timescale 1ns/1ps
module tb_bfp_top;
  import bfp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err_seen, charger = 0, load_off = 0;
  logic [4:0] cond = '0, cmp;
  logic test_mode = 0, oc_rel, od_rel, ocur_rel, test_sel;
  logic chg_gate, dis_gate, vm_pull_up, vm_pull_dn, standby;
  int errors = 0, n_compared = 0, n;
  wire [4:0] outs = {standby, vm_pull_dn, vm_pull_up, dis_gate, chg_gate};
  always #2.5 pclk = ~pclk;
  bfp_pack_model bfp_pack_model_i (.pclk(pclk), .presetn(presetn),
    .cond(cond), .charger(charger), .load_off(load_off),
    .test_mode(test_mode), .cmp(cmp), .oc_rel(oc_rel), .od_rel(od_rel),
    .ocur_rel(ocur_rel), .test_sel(test_sel));
  bfp_top bfp_top_i (.pclk(pclk), .presetn(presetn), .cen(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oc_cmp(cmp[0]), .od_cmp(cmp[1]), .ocur_cmp(cmp[2]), .sc_cmp(cmp[3]),
    .xchg_cmp(cmp[4]), .oc_rel(oc_rel), .od_rel(od_rel),
    .ocur_rel(ocur_rel), .test_sel(test_sel), .chg_gate(chg_gate),
    .dis_gate(dis_gate), .vm_pull_up(vm_pull_up), .vm_pull_dn(vm_pull_dn),
    .standby(standby));
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    chk(32'(k < 50), 32'h0000_0001);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset, then every delay register set to two ticks
  task automatic restart(input logic tm);
    // Mid-run resets start at a clock edge like every other input
    if (presetn)
      @(posedge pclk);
    cond <= '0;
    charger <= 1'b0;
    load_off <= 1'b0;
    test_mode <= tm;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NDLY; i++)
      apb(1'b1, REG_DLY_BASE + ADDR_W'(4 * i), 32'h0000_0002);
  endtask
  task automatic wait_out(input int b, input logic v);
    n = 0;
    @(posedge pclk);
    #1;
    while (outs[b] !== v && n < 6000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk(32'(n < 6000), 32'h0000_0001);
  endtask
  task automatic in_range(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask
  initial begin
    #300000;
    errors++;
    $display("watchdog expired");
    end_sim();
  end
  initial begin
    restart(1'b0);
    chk(32'(outs), 32'h0000_0003);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0300);
    apb(1'b1, REG_STATUS, 32'hFFFF_FFFF);
    chk(32'(err_seen), 32'h0000_0000);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0300);
    apb(1'b0, REG_DLY_LAST, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(err_seen), 32'h0000_0001);
    $display("test registers done");
    for (int tm = 0; tm < 2; tm++) begin
      restart(tm[0]);
      cond <= 5'h01;
      wait_out(0, 1'b0);
      if (tm == 0)
        in_range(TICK_CYC_I + 2, 2 * TICK_CYC_I + 1);
      else
        in_range(TICK_SHORT_I + 2, 2 * TICK_SHORT_I + 1);
      chk(32'(outs), 32'h0000_0002);
      cond <= 5'h00;
      wait_out(0, 1'b1);
    end
    $display("test over-charge delays done");
    restart(1'b1);
    cond <= 5'h12;
    wait_out(1, 1'b0);
    chk(32'(outs), 32'h0000_0015);
    repeat (100) @(posedge pclk);
    chk(32'(chg_gate), 32'h0000_0001);
    charger <= 1'b1;
    cond <= 5'h10;
    wait_out(4, 1'b0);
    wait_out(1, 1'b1);
    wait_out(0, 1'b0);
    in_range(TICK_SHORT_I + 1, 2 * TICK_SHORT_I);
    $display("test over-discharge and charger done");
    restart(1'b1);
    cond <= 5'h04;
    wait_out(3, 1'b1);
    chk(32'(outs), 32'h0000_0009);
    cond <= 5'h06;
    wait_out(2, 1'b1);
    chk(32'(outs), 32'h0000_0015);
    $display("test over-current then over-discharge done");
    restart(1'b1);
    cond <= 5'h03;
    wait_out(0, 1'b0);
    chk(32'(outs), 32'h0000_0002);
    wait_out(1, 1'b0);
    in_range(TICK_SHORT_I + 1, 2 * TICK_SHORT_I);
    chk(32'(outs), 32'h0000_0004);
    $display("test over-charge then over-discharge done");
    restart(1'b1);
    cond <= 5'h01;
    wait_out(0, 1'b0);
    cond <= 5'h05;
    repeat (200) @(posedge pclk);
    chk(32'(outs), 32'h0000_0002);
    restart(1'b1);
    cond <= 5'h04;
    wait_out(3, 1'b1);
    cond <= 5'h05;
    wait_out(0, 1'b0);
    chk(32'(outs), 32'h0000_0008);
    $display("test over-charge with over-current done");
    restart(1'b1);
    cond <= 5'h09;
    wait_out(1, 1'b0);
    in_range(SC_DLY_I, SC_DLY_I + 2);
    chk(32'(chg_gate), 32'h0000_0000);
    $display("test short-circuit done");
    end_sim();
  end
endmodule
